// ### logic/fpl_front_panel.sv
/*
 * fpl_front_panel: reset and abort pushbutton handling, panel indicators
 * and the register port that software uses to steer them.
 * assumes board status inputs come from logic on mclk; the two
 * pushbuttons are asynchronous pins.
 */
// Implementation choices: the register offsets and strobed register access.
// Operation
// - an unmasked reset button press pulses the board-wide reset output.
// - that press also drives the backplane system reset while this board is system controller.
// - a software control bit masks the reset button so presses do nothing.
// - an enabled abort press raises an interrupt request at the software-chosen level, none when disabled.
// - the fail lamp lights while board fail is active or the processor is halted.
// - the run lamp lights while the local bus transfer-in-progress signal is low.
// - the system controller lamp lights while the board is backplane system controller.
`timescale 1ns/1ps
module fpl_front_panel
    import fpl_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYCLES = fpl_pkg::DEBOUNCE_CYCLES,
    parameter int unsigned RESET_HOLD_CYCLES = fpl_pkg::RESET_HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [fpl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [fpl_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [fpl_pkg::DATA_W-1:0] regRdata,
    input wire logic resetButton_n,
    input wire logic abortButton_n,
    input wire logic boardFail_n,
    input wire logic cpuHalted,
    input wire logic transferInProgress_n,
    input wire logic systemController,
    output logic boardResetOut,
    output logic sysResetDrive,
    output logic abortIrq,
    output logic [fpl_pkg::LEVEL_W-1:0] abortIrqLevel,
    output logic irq,
    output logic failLed,
    output logic runLed,
    output logic systemControllerIndicator
);
    localparam int HOLD_W = $clog2(RESET_HOLD_CYCLES + 1);

    generate
        if (RESET_HOLD_CYCLES < 1) begin : g_bad_hold
            $error("fpl_front_panel: RESET_HOLD_CYCLES must be at least 1");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pushbutton conditioning

    logic resetPressed;
    logic resetPress;
    logic abortPressed;
    logic abortPress;

    fpl_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) u_reset_btn (
        .mclk(mclk),
        .reset_n(reset_n),
        .button_n(resetButton_n),
        .pressed(resetPressed),
        .press(resetPress)
    );

    fpl_debounce #(
        .STABLE_CYCLES(DEBOUNCE_CYCLES)
    ) u_abort_btn (
        .mclk(mclk),
        .reset_n(reset_n),
        .button_n(abortButton_n),
        .pressed(abortPressed),
        .press(abortPress)
    );

    ////////////////////////////////////////////////////////////////////////
    // control, status and mask registers

    logic resetMask;
    logic abortEnable;
    logic [LEVEL_W-1:0] abortLevel;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] irqMask;
    logic [EVT_W-1:0] evtSet;
    logic [EVT_W-1:0] evtClear;
    logic [EVT_W-1:0] next_status;
    logic resetStart;
    logic wrCtrl;
    logic wrStatus;
    logic wrMask;

    assign wrCtrl = regWrite && (regAddr == ADDR_CTRL);
    assign wrStatus = regWrite && (regAddr == ADDR_STATUS);
    assign wrMask = regWrite && (regAddr == ADDR_MASK);

    // masked presses are dropped here, before they touch anything
    assign resetStart = resetPress && !resetMask;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            resetMask <= CTRL_RESET[CTRL_RST_MASK];
            abortEnable <= CTRL_RESET[CTRL_ABORT_EN];
            abortLevel <= CTRL_RESET[CTRL_LEVEL_LSB +: LEVEL_W];
        end else if (wrCtrl) begin
            resetMask <= regWdata[CTRL_RST_MASK];
            abortEnable <= regWdata[CTRL_ABORT_EN];
            abortLevel <= regWdata[CTRL_LEVEL_LSB +: LEVEL_W];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irqMask <= EVT_NONE;
        end else if (wrMask) begin
            irqMask <= regWdata[EVT_W-1:0];
        end
    end

    // a disabled abort press sets no status bit; only the live button level still reads back at ADDR_STATE
    always_comb begin
        evtSet = EVT_NONE;
        evtSet[EVT_ABORT] = abortPress && abortEnable;
        evtSet[EVT_RESET] = resetStart;
    end

    assign evtClear = wrStatus ? regWdata[EVT_W-1:0] : EVT_NONE;

    // a new event beats a clear written in the same cycle
    assign next_status = (status & ~evtClear) | evtSet;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status <= EVT_NONE;
        end else begin
            status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt outputs

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & irqMask);
        end
    end

    // the request drops at once if software withdraws the enable
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            abortIrq <= 1'b0;
            abortIrqLevel <= '0;
        end else begin
            abortIrq <= next_status[EVT_ABORT] && abortEnable;
            abortIrqLevel <= (next_status[EVT_ABORT] && abortEnable) ? abortLevel : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // board and backplane reset

    logic [HOLD_W-1:0] holdCnt;

    // a press during the pulse restarts it rather than queueing a second
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            holdCnt <= '0;
            boardResetOut <= 1'b0;
            sysResetDrive <= 1'b0;
        end else if (resetStart) begin
            holdCnt <= HOLD_W'(RESET_HOLD_CYCLES - 1);
            boardResetOut <= 1'b1;
            sysResetDrive <= systemController;
        end else if (holdCnt != '0) begin
            holdCnt <= holdCnt - 1'b1;
            // losing the controller role mid-pulse stops the backplane drive
            sysResetDrive <= sysResetDrive && systemController;
        end else begin
            boardResetOut <= 1'b0;
            sysResetDrive <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indicators

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            failLed <= 1'b0;
            runLed <= 1'b0;
            systemControllerIndicator <= 1'b0;
        end else begin
            failLed <= !boardFail_n || cpuHalted;
            runLed <= !transferInProgress_n;
            systemControllerIndicator <= systemController;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port

    logic [DATA_W-1:0] next_rdata;

    // unmapped addresses read as zero
    always_comb begin
        next_rdata = '0;
        if (regRead) begin
            unique case (regAddr)
                ADDR_CTRL: begin
                    next_rdata[CTRL_RST_MASK] = resetMask;
                    next_rdata[CTRL_ABORT_EN] = abortEnable;
                    next_rdata[CTRL_LEVEL_LSB +: LEVEL_W] = abortLevel;
                end
                ADDR_STATUS: begin
                    next_rdata[EVT_W-1:0] = status;
                end
                ADDR_MASK: begin
                    next_rdata[EVT_W-1:0] = irqMask;
                end
                ADDR_STATE: begin
                    next_rdata[ST_ABORT_BTN] = abortPressed;
                    next_rdata[ST_RESET_BTN] = resetPressed;
                    next_rdata[ST_BRD_RESET] = boardResetOut;
                    next_rdata[ST_SYS_CON] = systemController;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata <= '0;
        end else begin
            regRdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_reset_start;
        @(posedge mclk) disable iff (!reset_n)
        resetPress && !resetMask |=> boardResetOut;
    endproperty
    a_reset_start: assert property (p_reset_start) else $error("unmasked press gave no reset");

    property p_reset_masked;
        @(posedge mclk) disable iff (!reset_n)
        resetPress && resetMask && !boardResetOut |=> !boardResetOut;
    endproperty
    a_reset_masked: assert property (p_reset_masked) else $error("masked press caused reset");

    property p_sys_drive;
        @(posedge mclk) disable iff (!reset_n)
        resetPress && !resetMask |=> sysResetDrive == $past(systemController);
    endproperty
    a_sys_drive: assert property (p_sys_drive) else $error("system reset drive wrong");

    property p_sys_inside;
        @(posedge mclk) disable iff (!reset_n)
        sysResetDrive |-> boardResetOut;
    endproperty
    a_sys_inside: assert property (p_sys_inside) else $error("system reset outside board reset");

    property p_abort_raise;
        @(posedge mclk) disable iff (!reset_n)
        abortPress && abortEnable && !wrCtrl |=>
            abortIrq && (abortIrqLevel == $past(abortLevel)) && status[EVT_ABORT];
    endproperty
    a_abort_raise: assert property (p_abort_raise) else $error("abort request missing or wrong level");

    property p_abort_off;
        @(posedge mclk) disable iff (!reset_n)
        !abortEnable |=> !abortIrq && (abortIrqLevel == '0);
    endproperty
    a_abort_off: assert property (p_abort_off) else $error("abort request while disabled");

    property p_fail_led;
        @(posedge mclk) disable iff (!reset_n)
        1'b1 |=> failLed == $past(!boardFail_n || cpuHalted);
    endproperty
    a_fail_led: assert property (p_fail_led) else $error("fail lamp wrong");

    property p_run_led;
        @(posedge mclk) disable iff (!reset_n)
        $fell(transferInProgress_n) |=> runLed;
    endproperty
    a_run_led: assert property (p_run_led) else $error("run lamp not lit");

    property p_system_controller_indicator_led;
        @(posedge mclk) disable iff (!reset_n)
        systemController != systemControllerIndicator |=>
            systemControllerIndicator == $past(systemController);
    endproperty
    a_system_controller_indicator_led: assert property (p_system_controller_indicator_led) else $error("system controller lamp stale");

    property p_set_wins;
        @(posedge mclk) disable iff (!reset_n)
        resetStart && wrStatus && regWdata[EVT_RESET] |=> status[EVT_RESET];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("reset event lost to clear");

    property p_cv_sysreset;
        @(posedge mclk) disable iff (!reset_n)
        resetStart && systemController ##1 sysResetDrive;
    endproperty
    c_sysreset: cover property (p_cv_sysreset);

    property p_cv_abort;
        @(posedge mclk) disable iff (!reset_n)
        abortPress && abortEnable ##1 abortIrq && irq;
    endproperty
    c_abort: cover property (p_cv_abort);

    property p_cv_masked;
        @(posedge mclk) disable iff (!reset_n)
        resetPress && resetMask;
    endproperty
    c_masked: cover property (p_cv_masked);

endmodule

// ### shared/fpl_pkg.sv
/*
 * fpl_pkg: constants shared by the front panel switch and indicator logic.
 * assumes a single 25 MHz local clock and the plain register port of the
 * front panel block.
 */
package fpl_pkg;

    // clock rate
    localparam int unsigned CLK_HZ = 25000000;

    // contact bounce settles well inside this time
    localparam int unsigned DEBOUNCE_MS = 10;
    localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_MS * (CLK_HZ / 1000));

    // board reset pulse width produced by one press
    localparam int unsigned RESET_HOLD_MS = 1;
    localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_MS * (CLK_HZ / 1000));

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h0C;

    // control fields
    localparam int CTRL_RST_MASK = 0;
    localparam int CTRL_ABORT_EN = 1;
    localparam int CTRL_LEVEL_LSB = 2;
    localparam int LEVEL_W = 3;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // event bits, shared by status and mask
    localparam int EVT_ABORT = 0;
    localparam int EVT_RESET = 1;
    localparam int EVT_W = 2;
    localparam logic [EVT_W-1:0] EVT_NONE = 2'h0;

    // live state fields
    localparam int ST_ABORT_BTN = 0;
    localparam int ST_RESET_BTN = 1;
    localparam int ST_BRD_RESET = 2;
    localparam int ST_SYS_CON = 3;

endpackage

// ### logic/fpl_debounce.sv
/*
 * fpl_debounce: synchroniser and debouncer for one active-low pushbutton.
 * assumes the button pin is asynchronous to mclk and bounces for less
 * than STABLE_CYCLES clock periods.
 */
`timescale 1ns/1ps
module fpl_debounce #(
    parameter int unsigned STABLE_CYCLES = 16
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic button_n,
    output logic pressed,
    output logic press
);
    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

    logic sync1;
    logic sync2;
    logic sync3;
    logic [CNT_W-1:0] count;
    logic agree;
    logic raw;

    generate
        if (STABLE_CYCLES < 2) begin : g_bad
            $error("fpl_debounce: STABLE_CYCLES must be at least 2");
        end
    endgenerate

    // released level at reset, so no false press comes out of reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
        end else begin
            sync1 <= button_n;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign agree = (sync2 == sync3);
    assign raw = ~sync3;

    // any disagreement or return to the old level restarts the wait
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            pressed <= 1'b0;
            press <= 1'b0;
        end else begin
            press <= 1'b0;
            if (agree && (raw != pressed)) begin
                if (count == CNT_W'(STABLE_CYCLES - 1)) begin
                    count <= '0;
                    pressed <= raw;
                    press <= raw;
                end else begin
                    count <= count + 1'b1;
                end
            end else begin
                count <= '0;
            end
        end
    end

    property p_press_once;
        @(posedge mclk) disable iff (!reset_n)
        press |=> !press;
    endproperty
    a_press_once: assert property (p_press_once) else $error("press pulse longer than one cycle");

    property p_press_edge;
        @(posedge mclk) disable iff (!reset_n)
        press |-> pressed && !$past(pressed);
    endproperty
    a_press_edge: assert property (p_press_edge) else $error("press without new level");

endmodule

// ### sim/fpl_panel_model.sv
/*
 * fpl_panel_model: the two front panel pushbuttons, with contact bounce.
 * assumes buttons are pulled up (released = high); bounce toggles the pin every
 * clock period, so no bounce level holds for the debounce count the bench sets.
 */
`timescale 1ns/1ps
module fpl_panel_model (
    input wire logic mclk,
    output logic resetButton_n,
    output logic abortButton_n
);
    initial begin
        resetButton_n = 1'b1;
        abortButton_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic setPin(input bit isReset, input logic val);
        if (isReset) begin
            resetButton_n <= val;
        end else begin
            abortButton_n <= val;
        end
    endtask

    // chatter on both edges of the press, one cycle per bounce
    task automatic press(input bit isReset, input int holdCycles);
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            setPin(isReset, i[0]);
        end
        repeat (holdCycles) @(posedge mclk);
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            setPin(isReset, ~i[0]);
        end
    endtask
endmodule

// ### sim/tb_fpl_front_panel.sv
/*
 * tb_fpl_front_panel: self-checking bench for the front panel block.
 * assumes short debounce and reset pulse counts so presses finish quickly.
 */
`timescale 1ns/1ps
module tb_fpl_front_panel;
    import fpl_pkg::*;
    localparam int unsigned DEB = 4;
    localparam int unsigned HOLD = 3;

    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic resetButton_n, abortButton_n;
    logic boardFail_n = 1'b1;
    logic cpuHalted = 1'b0;
    logic transferInProgress_n = 1'b1;
    logic systemController = 1'b0;
    logic boardResetOut, sysResetDrive, abortIrq, irq;
    logic failLed, runLed, systemControllerIndicator;
    logic [LEVEL_W-1:0] abortIrqLevel;
    int badCount = 0;
    int comparisons = 0;
    int rstPulses, rstHigh, sysSeen, abortRise;
    logic prevRst = 1'b0;
    logic prevAb = 1'b0;

    always #20 mclk = ~mclk;

    fpl_front_panel #(.DEBOUNCE_CYCLES(DEB), .RESET_HOLD_CYCLES(HOLD)) dut_u (
        .mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .resetButton_n(resetButton_n), .abortButton_n(abortButton_n),
        .boardFail_n(boardFail_n), .cpuHalted(cpuHalted),
        .transferInProgress_n(transferInProgress_n), .systemController(systemController),
        .boardResetOut(boardResetOut), .sysResetDrive(sysResetDrive), .abortIrq(abortIrq),
        .abortIrqLevel(abortIrqLevel), .irq(irq), .failLed(failLed), .runLed(runLed),
        .systemControllerIndicator(systemControllerIndicator)
    );

    fpl_panel_model panel_u (
        .mclk(mclk), .resetButton_n(resetButton_n), .abortButton_n(abortButton_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pulse and cycle counts seen on the event outputs
    always @(posedge mclk) begin
        if (boardResetOut && !prevRst) rstPulses++;
        if (boardResetOut) rstHigh++;
        if (sysResetDrive) sysSeen++;
        if (abortIrq && !prevAb) abortRise++;
        prevRst <= boardResetOut;
        prevAb <= abortIrq;
    end

    task automatic clearMon();
        rstPulses = 0;
        rstHigh = 0;
        sysSeen = 0;
        abortRise = 0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (badCount == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic regWr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    task automatic regRd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic resetValues();
        logic [DATA_W-1:0] d;
        regRd(ADDR_CTRL, d);
        check(d, 32'h0);
        regRd(ADDR_STATUS, d);
        check(d, 32'h0);
        regRd(ADDR_MASK, d);
        check(d, 32'h0);
        regRd(8'h10, d);
        check(d, 32'h0);
    endtask

    // every combination of the four board status inputs
    task automatic lampCase();
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            @(posedge mclk);
            boardFail_n <= v[0];
            cpuHalted <= v[1];
            transferInProgress_n <= v[2];
            systemController <= v[3];
            repeat (2) @(posedge mclk);
            #1;
            check(failLed, !v[0] || v[1]);
            check(runLed, !v[2]);
            check(systemControllerIndicator, v[3]);
        end
    endtask

    // a bouncing reset press, masked or not, with or without controller role
    task automatic resetCase(input logic [DATA_W-1:0] ctrlVal, input logic sysCon);
        logic [DATA_W-1:0] d;
        int n;
        n = ctrlVal[CTRL_RST_MASK] ? 0 : 1;
        regWr(ADDR_CTRL, ctrlVal);
        @(posedge mclk);
        systemController <= sysCon;
        #1 clearMon();
        fork
            panel_u.press(1'b1, 12);
            begin
                // five bounce edges, three sync stages, then the debounce count:
                // the clear strobe meets the press pulse, so the set must win
                repeat (7 + DEB) @(posedge mclk);
                regWr(ADDR_STATUS, 32'h2);
                regRd(ADDR_STATE, d);
                check(d, (1 << ST_RESET_BTN) | (n << ST_BRD_RESET) | (32'(sysCon) << ST_SYS_CON));
            end
        join
        repeat (12) @(posedge mclk);
        #1;
        check(rstPulses, n);
        check(rstHigh, n * HOLD);
        check(sysSeen, n * HOLD * sysCon);
        check(irq, n);
        regRd(ADDR_STATUS, d);
        check(d, n << EVT_RESET);
        regWr(ADDR_STATUS, 32'h2);
        @(posedge mclk);
        #1 check(irq, 1'b0);
    endtask

    // abort press at a given level; the abort event reaches irq only when unmasked
    task automatic abortCase(input logic en, input logic [LEVEL_W-1:0] lvl, input logic unmask);
        logic [DATA_W-1:0] d;
        regWr(ADDR_MASK, {30'h0, 1'b1, unmask});
        regWr(ADDR_CTRL, {27'h0, lvl, en, 1'b0});
        #1 clearMon();
        panel_u.press(1'b0, 12);
        repeat (12) @(posedge mclk);
        #1;
        check(abortRise, en);
        check(abortIrq, en);
        check(abortIrqLevel, en ? lvl : 3'h0);
        check(irq, en && unmask);
        regRd(ADDR_STATUS, d);
        check(d, en);
        regWr(ADDR_STATUS, 32'h1);
        @(posedge mclk);
        #1 check(abortIrq, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        resetValues();
        lampCase();
        regWr(ADDR_MASK, 32'h2);
        resetCase(32'h0, 1'b1);
        resetCase(32'h0, 1'b0);
        resetCase(32'h1, 1'b1);
        for (int l = 0; l < 8; l++) begin
            abortCase(1'b1, l[2:0], l[0]);
        end
        abortCase(1'b0, 3'h5, 1'b1);
        final_report();
    end
endmodule
